/* File: hw/clk_synth_ctrl.sv */
// Clock synthesizer control: clock source strap, synthesizer control
// register, lock tracking, power-up reset hold and lock interrupts.
// Assumes one 200 MHz clock, synchronous inputs, single-cycle register port.
// Functional notes
// (R1) Strap low at reset: loop disabled, external clock used directly.
// (R2) Strap high at reset: synthesizer makes clock from reference and control register.
// (R3) Divide select 0 (reset) gives oscillator over four; 1 gives over two.
// (R4) Oscillator is four or two times system frequency, keeping 50% duty.
// (R5) System frequency is ref/128 times 4(modulus+1) times 2^(2W+X).
// (R6) Control register resets to 3F00 hex, 8.388 MHz from 4.194 MHz.
// (R7) One prescale bit and six modulus bits set feedback, multiply up to 256.
// (R8) Changing prescale or modulus starts a relock interval.
// (R9) Changing divide select acts at once, with no relock.
// (R10) Any change at a comparator input, reference or feedback, forces relock.
// (R11) Lock status is readable as a flag in the control register.
// (R12) At power-up the device stays in reset until the synthesizer locks.
// (R13) Software only programs settings giving a frequency within operating limits.
// (R14) Lock flag reads not locked from a feedback change until relock ends.
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "clk_synth_regs.svh"

module clk_synth_ctrl #(
    parameter clk_synth_pkg::freq_t REF_FREQ_HZ = `REF_FREQ_HZ,
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int RELOCK_TICKS = `RELOCK_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Clock source strap and reference disturbance
    input wire logic i_clock_source_strap,
    input wire logic i_ref_change,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Clock control outputs
    output logic o_pll_enable,
    output logic o_sys_div_two,
    output clk_synth_pkg::freq_t o_sys_freq_hz,
    output clk_synth_pkg::freq_t o_vco_freq_hz,
    output logic o_synth_lock_flag,
    output logic o_sys_rstn,
    // Interrupt
    output logic o_irq
);
    import clk_synth_pkg::*;

    localparam logic [15:0] CTRL_RST = `CTRL_RESET;

    // ****************************************************************
    // Declarations and decode helpers
    // ****************************************************************

    synth_cfg_if cfg ();

    ctl_s st_r;
    ctl_s st_nxt;
    logic wr_ctrl;
    logic wr_sts;
    logic wr_msk;
    logic wy_change;
    logic retrigger;
    logic [1:0] events;
    logic [1:0] sts_clr;

    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction : hit

    function automatic logic [31:0] ctrl_word(input ctl_s s);
        logic [31:0] v;
        v = 32'h0;
        v[`CTRL_W_BIT] = s.fb_prescale;
        v[`CTRL_X_BIT] = s.out_div_two;
        v[`CTRL_Y_HI:`CTRL_Y_LO] = s.fb_modulus;
        v[`CTRL_LOCK_BIT] = (s.state == ST_LOCKED); // R11
        v[`CTRL_PLL_BIT] = s.pll_on;
        return v;
    endfunction : ctrl_word

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    always_comb begin
        wr_ctrl = i_wr && hit(i_addr, `CTRL_OFS);
        wr_sts = i_wr && hit(i_addr, `INT_STS_OFS);
        wr_msk = i_wr && hit(i_addr, `INT_MSK_OFS);
        // Only the feedback fields move the oscillator
        wy_change = wr_ctrl && st_r.pll_on
            && ({i_wdata[`CTRL_W_BIT], i_wdata[`CTRL_Y_HI:`CTRL_Y_LO]}
            != {st_r.fb_prescale, st_r.fb_modulus}); // R8 R9
        retrigger = st_r.pll_on && (wy_change || i_ref_change); // R10
        cfg.relock_start = retrigger
            || (st_r.state == ST_ACQUIRE && !cfg.relock_busy && !cfg.relock_done);
        events = 2'h0;
        sts_clr = wr_sts ? i_wdata[`EV_LOST_BIT:`EV_LOCK_BIT] : 2'h0;

        st_nxt = st_r;
        st_nxt.rdata = 32'h0;

        unique case (st_r.state)
            ST_EXT: begin
                // Loop off: nothing to wait for
                st_nxt.por_done = 1'h1; // R1 R12
            end
            ST_ACQUIRE: begin
                if (cfg.relock_done && !retrigger) begin
                    st_nxt.state = ST_LOCKED; // R14
                    st_nxt.por_done = 1'h1; // R12
                    events[`EV_LOCK_BIT] = 1'h1;
                end
            end
            ST_LOCKED: begin
                if (retrigger) begin
                    st_nxt.state = ST_ACQUIRE; // R8 R10 R14
                    events[`EV_LOST_BIT] = 1'h1;
                end
            end
            default: begin
                st_nxt.state = st_r.pll_on ? ST_ACQUIRE : ST_EXT;
            end
        endcase

        // Control register: divide select applies at once
        if (wr_ctrl) begin
            st_nxt.fb_prescale = i_wdata[`CTRL_W_BIT]; // R7
            st_nxt.out_div_two = i_wdata[`CTRL_X_BIT]; // R3 R9
            st_nxt.fb_modulus = i_wdata[`CTRL_Y_HI:`CTRL_Y_LO]; // R7
        end

        // Interrupts: write one to clear, a new event wins
        if (wr_msk) begin
            st_nxt.msk = i_wdata[`EV_LOST_BIT:`EV_LOCK_BIT];
        end
        st_nxt.sts = (st_r.sts & ~sts_clr) | events;

        // Read data stand only in the cycle after the strobe
        if (i_rd) begin
            if (hit(i_addr, `CTRL_OFS)) begin
                st_nxt.rdata = ctrl_word(st_r); // R11
            end else if (hit(i_addr, `INT_STS_OFS)) begin
                st_nxt.rdata = 32'(st_r.sts);
            end else if (hit(i_addr, `INT_MSK_OFS)) begin
                st_nxt.rdata = 32'(st_r.msk);
            end else if (hit(i_addr, `FSYS_OFS)) begin
                st_nxt.rdata = cfg.fsys; // R5
            end else if (hit(i_addr, `FVCO_OFS)) begin
                st_nxt.rdata = cfg.fvco; // R4
            end
        end

        // Strap is caught in every reset cycle, the last one counts
        if (!i_rstn) begin
            st_nxt = '0;
            st_nxt.pll_on = i_clock_source_strap; // R1 R2
            st_nxt.state = i_clock_source_strap ? ST_ACQUIRE : ST_EXT; // R1 R2
            st_nxt.fb_prescale = CTRL_RST[`CTRL_W_BIT]; // R6
            st_nxt.out_div_two = CTRL_RST[`CTRL_X_BIT]; // R6
            st_nxt.fb_modulus = CTRL_RST[`CTRL_Y_HI:`CTRL_Y_LO]; // R6
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    // ****************************************************************
    // Frequency calculation and relock timing
    // ****************************************************************

    assign cfg.pll_on = st_r.pll_on;
    assign cfg.fb_prescale = st_r.fb_prescale;
    assign cfg.out_div_two = st_r.out_div_two;
    assign cfg.fb_modulus = st_r.fb_modulus;

    freq_calc #(
        .REF_FREQ_HZ(REF_FREQ_HZ)
    ) u_calc (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .cfg(cfg.calc)
    );

    relock_timer #(
        .TICK_CYCLES(TICK_CYCLES),
        .RELOCK_TICKS(RELOCK_TICKS)
    ) u_timer (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .tmr(cfg.timer)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************

    assign o_rdata = st_r.rdata;
    assign o_pll_enable = st_r.pll_on; // R1 R2
    assign o_sys_div_two = cfg.div_two;
    assign o_sys_freq_hz = cfg.fsys;
    assign o_vco_freq_hz = cfg.fvco;
    assign o_synth_lock_flag = (st_r.state == ST_LOCKED); // R11
    assign o_sys_rstn = st_r.por_done; // R12
    assign o_irq = |(st_r.sts & st_r.msk);

    // ****************************************************************
    // Assertions and cover points
    // ****************************************************************

    logic [41:0] exp_prod;
    freq_t exp_fsys;

    always_comb begin
        exp_prod = 42'(REF_FREQ_HZ) * (42'(st_r.fb_modulus) + 42'h1);
        exp_prod = exp_prod << {st_r.fb_prescale, st_r.out_div_two};
        exp_fsys = exp_prod[`REF_DIV_SHIFT +: 32];
    end

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rstn);

    ext_loop_off_a: assert property ( // R1
        (st_r.state == ST_EXT) [*3]
        |-> !o_pll_enable && !o_synth_lock_flag
        && o_sys_freq_hz == REF_FREQ_HZ && o_vco_freq_hz == 32'h0)
        else $error("external clock mode not using the input clock");

    pll_mode_a: assert property ( // R2
        o_pll_enable |-> st_r.state != ST_EXT)
        else $error("loop enabled while in external clock mode");

    out_divide_a: assert property ( // R4
        o_pll_enable |-> o_vco_freq_hz == (o_sys_div_two
        ? {o_sys_freq_hz[30:0], 1'h0} : {o_sys_freq_hz[29:0], 2'h0}))
        else $error("oscillator and system frequency ratio wrong");

    div_follow_a: assert property ( // R3
        wr_ctrl ##1 !wr_ctrl
        |-> ##1 o_sys_div_two == $past(i_wdata[`CTRL_X_BIT], 2))
        else $error("divide select not applied two cycles after write");

    reset_value_a: assert property ( // R6
        $rose(i_rstn) |-> {st_r.fb_prescale, st_r.out_div_two, st_r.fb_modulus}
        == CTRL_RST[`CTRL_W_BIT:`CTRL_Y_LO] && !o_synth_lock_flag)
        else $error("control register reset value wrong");

    sys_freq_a: assert property ( // R5
        (st_r.pll_on && $stable({st_r.fb_prescale, st_r.out_div_two,
        st_r.fb_modulus})) [*3] |-> o_sys_freq_hz == exp_fsys)
        else $error("system frequency does not follow the settings");

    fb_relock_a: assert property ( // R8
        wy_change |=> !o_synth_lock_flag [*2])
        else $error("feedback change did not drop lock");

    div_no_relock_a: assert property ( // R9
        wr_ctrl && o_synth_lock_flag && !wy_change && !i_ref_change
        |=> o_synth_lock_flag)
        else $error("divide select change caused a relock");

    ref_relock_a: assert property ( // R10
        i_ref_change && o_pll_enable |=> !o_synth_lock_flag)
        else $error("reference change did not force relock");

    lock_read_a: assert property ( // R11
        i_rd && hit(i_addr, `CTRL_OFS)
        |=> o_rdata[`CTRL_LOCK_BIT] == $past(o_synth_lock_flag))
        else $error("lock flag read back wrong");

    por_hold_a: assert property ( // R12
        $rose(o_sys_rstn) |-> o_synth_lock_flag || !o_pll_enable)
        else $error("power-up reset released before lock");

    lock_low_a: assert property ( // R14
        o_pll_enable && !o_synth_lock_flag && !cfg.relock_done
        |=> !o_synth_lock_flag)
        else $error("lock flag set before relock interval ended");

    lock_irq_a: assert property (
        $rose(o_synth_lock_flag) && st_r.msk[`EV_LOCK_BIT] |-> o_irq)
        else $error("unmasked lock event gave no interrupt");

    // ****************************************************************
    // Strap, reset release, timer, status and register port checks
    // ****************************************************************

    strap_mode_a: assert property ( // R1 R2
        $rose(i_rstn)
        |-> o_pll_enable == $past(i_clock_source_strap))
        else $error("loop mode does not follow the strap");

    ext_release_a: assert property ( // R1 R12
        $rose(i_rstn) && !o_pll_enable
        |=> o_sys_rstn)
        else $error("external clock mode held the reset");

    ext_timer_idle_a: assert property ( // R1
        !o_pll_enable
        |-> !cfg.relock_busy && !cfg.relock_done)
        else $error("relock timer running with the loop off");

    por_before_lock_a: assert property ( // R12
        o_pll_enable && !o_sys_rstn
        |-> !o_synth_lock_flag)
        else $error("lock reported while reset still held");

    start_busy_a: assert property ( // R8
        wy_change
        |=> cfg.relock_busy)
        else $error("feedback change did not start the timer");

    busy_unlocked_a: assert property ( // R14
        cfg.relock_busy
        |-> !o_synth_lock_flag)
        else $error("lock flag high during relock interval");

    lock_event_a: assert property (
        $rose(o_synth_lock_flag)
        |-> st_r.sts[`EV_LOCK_BIT])
        else $error("lock gained without status event");

    lost_event_a: assert property (
        $fell(o_synth_lock_flag)
        |-> st_r.sts[`EV_LOST_BIT])
        else $error("lock lost without status event");

    sts_clear_a: assert property (
        wr_sts && i_wdata[`EV_LOST_BIT] && !events[`EV_LOST_BIT]
        |=> !st_r.sts[`EV_LOST_BIT])
        else $error("lost-lock status not cleared by write");

    rdata_idle_a: assert property (
        !i_rd
        |=> o_rdata == 32'h0)
        else $error("read data outside the answer cycle");

    lock_seen_c: cover property ($rose(o_synth_lock_flag));
    relock_c: cover property (o_synth_lock_flag && wy_change ##1 !o_synth_lock_flag);
    ext_run_c: cover property (st_r.state == ST_EXT && o_sys_rstn);
    irq_c: cover property ($rose(o_irq));
    div_only_c: cover property (wr_ctrl && o_synth_lock_flag && !wy_change);
endmodule : clk_synth_ctrl

/* File: inc/clk_synth_regs.svh */
// Register offsets, field positions, reset values and timing counts
// for the clock synthesizer control. Definitions only.
`ifndef CLK_SYNTH_REGS_SVH
`define CLK_SYNTH_REGS_SVH

// Register byte offsets
`define CTRL_OFS 8'h00
`define INT_STS_OFS 8'h04
`define INT_MSK_OFS 8'h08
`define FSYS_OFS 8'h0C
`define FVCO_OFS 8'h10

// Control register fields and reset value
`define CTRL_RESET 16'h3F00
`define CTRL_W_BIT 15
`define CTRL_X_BIT 14
`define CTRL_Y_HI 13
`define CTRL_Y_LO 8
`define CTRL_LOCK_BIT 3
`define CTRL_PLL_BIT 0

// Interrupt status and mask fields
`define EV_LOCK_BIT 0
`define EV_LOST_BIT 1

// Reference frequency (4.194 MHz) and the divide by 128, times 4
`define REF_FREQ_HZ 32'h003FFED0
`define REF_DIV_SHIFT 5

// Timing: clock period, divider tick and relock interval
`define CLK_PERIOD_PS 5000
`define PS_PER_NS 1000
`define NS_PER_US 1000
`define TICK_TIME_NS 1000
`define RELOCK_TIME_US 20
`define TICK_CYCLES ((`TICK_TIME_NS * `PS_PER_NS) / `CLK_PERIOD_PS)
`define RELOCK_TICKS ((`RELOCK_TIME_US * `NS_PER_US) / `TICK_TIME_NS)

`endif

/* File: inc/clk_synth_pkg.sv */
// Types shared by the clock synthesizer control modules.
// Offsets and counts live in clk_synth_regs.svh.
package clk_synth_pkg;
    typedef logic [31:0] freq_t;

    typedef enum logic [2:0] {
        ST_EXT = 3'h1,
        ST_ACQUIRE = 3'h2,
        ST_LOCKED = 3'h4
    } synth_state_e;

    typedef struct packed {
        synth_state_e state;
        logic pll_on;
        logic fb_prescale;
        logic out_div_two;
        logic [5:0] fb_modulus;
        logic [1:0] sts;
        logic [1:0] msk;
        logic por_done;
        logic [31:0] rdata;
    } ctl_s;

    typedef struct packed {
        freq_t fsys;
        freq_t fvco;
        logic div_two;
    } calc_s;

    typedef struct packed {
        logic [15:0] div;
        logic [15:0] ticks;
        logic busy;
        logic done;
    } timer_s;
endpackage : clk_synth_pkg

/* File: inc/synth_cfg_if.sv */
// Settings and results passed between the control, the frequency
// calculator and the relock timer. All signals in the i_clk domain.
`timescale 1ns/1ps
interface synth_cfg_if;
    logic pll_on;
    logic fb_prescale;
    logic out_div_two;
    logic [5:0] fb_modulus;
    logic relock_start;
    logic relock_busy;
    logic relock_done;
    clk_synth_pkg::freq_t fsys;
    clk_synth_pkg::freq_t fvco;
    logic div_two;

    modport calc (
        input pll_on, fb_prescale, out_div_two, fb_modulus,
        output fsys, fvco, div_two
    );
    modport timer (
        input relock_start,
        output relock_busy, relock_done
    );
endinterface : synth_cfg_if

/* File: hw/freq_calc.sv */
// System and oscillator frequency from the synthesizer settings.
// Assumes settings come from flops in the same clock domain.
`timescale 1ns/1ps
`include "clk_synth_regs.svh"

module freq_calc #(
    parameter clk_synth_pkg::freq_t REF_FREQ_HZ = `REF_FREQ_HZ
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Settings in, frequencies out
    synth_cfg_if.calc cfg
);
    import clk_synth_pkg::*;

    calc_s st_r;
    calc_s st_nxt;
    logic [41:0] prod;

    always_comb begin
        // Reference times (modulus + 1), shifted by 2W+X, over 32
        prod = 42'(REF_FREQ_HZ) * 42'(7'(cfg.fb_modulus) + 7'h01); // R5 R7
        prod = prod << {cfg.fb_prescale, cfg.out_div_two}; // R5
        st_nxt = st_r;
        // Software keeps settings in range, so 32 bits suffice
        st_nxt.fsys = cfg.pll_on ? prod[`REF_DIV_SHIFT +: 32] : REF_FREQ_HZ; // R1 R2 R13
        st_nxt.div_two = cfg.out_div_two; // R3
        if (!cfg.pll_on) begin
            st_nxt.fvco = 32'h0; // R1
        end else if (cfg.out_div_two) begin
            st_nxt.fvco = {st_nxt.fsys[30:0], 1'h0}; // R4
        end else begin
            st_nxt.fvco = {st_nxt.fsys[29:0], 2'h0}; // R4
        end
        if (!i_rstn) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    assign cfg.fsys = st_r.fsys;
    assign cfg.fvco = st_r.fvco;
    assign cfg.div_two = st_r.div_two;
endmodule : freq_calc

/* File: hw/relock_timer.sv */
// Relock interval: a divider makes a one-cycle tick, ticks are counted.
// Assumes relock_start is a one-cycle request; a new start restarts it.
`timescale 1ns/1ps
`include "clk_synth_regs.svh"

module relock_timer #(
    parameter int TICK_CYCLES = `TICK_CYCLES,
    parameter int RELOCK_TICKS = `RELOCK_TICKS
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Start in, busy and done out
    synth_cfg_if.timer tmr
);
    import clk_synth_pkg::*;

    localparam logic [15:0] DIV_LAST = 16'(TICK_CYCLES - 1);
    localparam logic [15:0] TICK_LAST = 16'(RELOCK_TICKS - 1);

    timer_s st_r;
    timer_s st_nxt;
    logic tick;

    always_comb begin
        tick = st_r.busy && (st_r.div == DIV_LAST);
        st_nxt = st_r;
        st_nxt.done = 1'h0;
        if (tmr.relock_start) begin
            st_nxt.busy = 1'h1; // R8 R10
            st_nxt.div = 16'h0;
            st_nxt.ticks = 16'h0;
        end else if (tick) begin
            st_nxt.div = 16'h0;
            if (st_r.ticks == TICK_LAST) begin
                st_nxt.busy = 1'h0;
                st_nxt.done = 1'h1;
            end else begin
                st_nxt.ticks = st_r.ticks + 16'h1;
            end
        end else if (st_r.busy) begin
            st_nxt.div = st_r.div + 16'h1;
        end
        if (!i_rstn) begin
            st_nxt = '0;
        end
    end

    always_ff @(posedge i_clk) begin
        st_r <= st_nxt;
    end

    assign tmr.relock_busy = st_r.busy;
    assign tmr.relock_done = st_r.done;
endmodule : relock_timer

/* File: testbench/ref_clock_source.sv */
// Reference source model: reports a disturbance of the reference input.
// Assumes the bench raises i_disturb for one cycle after a rising edge.
`timescale 1ns/1ps

module ref_clock_source (
    // Clock
    input wire logic i_clk,
    // Command from the bench
    input wire logic i_disturb,
    // Disturbance pulse towards the synthesizer
    output logic o_ref_change
);
    initial o_ref_change = 1'b0;

    // One-cycle pulse, launched just after the edge like any source
    always @(posedge i_clk) begin
        o_ref_change <= i_disturb;
    end
endmodule : ref_clock_source

/* File: testbench/clock_synthesizer_control_tb.sv */
// Self-checking bench for the clock synthesizer control.
// Assumes short relock counts and the single-cycle register port.
`timescale 1ns/1ps
`include "clk_synth_regs.svh"

module clock_synthesizer_control_tb;
    import clk_synth_pkg::*;

    localparam int TICKS = 4;
    localparam int RLK = 3;
    localparam int T_LOCK = TICKS * RLK;
    localparam logic [31:0] REF = 32'h003FFED0;

    logic i_clk, i_rstn, i_strap, i_disturb, i_ref_change, i_wr, i_rd;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic o_pll_enable, o_sys_div_two, o_lock, o_sys_rstn, o_irq;
    freq_t o_fsys, o_fvco;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;

    // ****************************************************************
    // Clock, design and reference source
    // ****************************************************************
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    clk_synth_ctrl #(.TICK_CYCLES(TICKS), .RELOCK_TICKS(RLK)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_clock_source_strap(i_strap),
        .i_ref_change(i_ref_change), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_pll_enable(o_pll_enable),
        .o_sys_div_two(o_sys_div_two), .o_sys_freq_hz(o_fsys), .o_vco_freq_hz(o_fvco),
        .o_synth_lock_flag(o_lock), .o_sys_rstn(o_sys_rstn), .o_irq(o_irq)
    );

    ref_clock_source src (.i_clk(i_clk), .i_disturb(i_disturb), .o_ref_change(i_ref_change));

    // ****************************************************************
    // Checking and closing
    // ****************************************************************
    task automatic report_and_stop;
        $display("checks %0d, errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check_word

    task automatic check_bit(input string name, input logic exp, input logic got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %b, seen %b", name, exp, got);
        end
    endtask : check_bit

    // Hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_errors++;
            report_and_stop();
        end
    end

    // ****************************************************************
    // Register port and helpers
    // ****************************************************************
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : reg_read

    task automatic do_reset(input logic strap);
        @(posedge i_clk);
        i_rstn <= 1'b0;
        i_strap <= strap;
        repeat (4) @(posedge i_clk);
        i_rstn <= 1'b1;
        @(posedge i_clk);
        #1;
    endtask : do_reset

    // Waits for lock and checks the relock time against the interval
    task automatic wait_lock(input string name);
        int n;
        n = 0;
        while (o_lock !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            #1;
            n++;
        end
        check_bit(name, 1'b1, n >= T_LOCK - 2 && n <= T_LOCK + 4);
    endtask : wait_lock

    function automatic logic [31:0] ctrl_word(logic w, logic x, logic [5:0] y, logic lk,
                                              logic pll);
        return {16'h0000, w, x, y, 4'h0, lk, 2'b00, pll};
    endfunction : ctrl_word

    function automatic logic [31:0] fsys_of(logic w, logic x, logic [5:0] y);
        logic [63:0] f;
        f = (64'(REF) * (64'(y) + 64'h1)) << (2 * w + x);
        return f[36:5];
    endfunction : fsys_of

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    logic [31:0] rd;
    logic [8:0] cfg [6] = '{9'h080, 9'h07F, 9'h0C0, 9'h03F, 9'h0D3, 9'h000};

    initial begin
        i_rstn = 1'b0;
        i_strap = 1'b1;
        i_disturb = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h00000000;
        do_reset(1'b1);
        check_bit("held reset", 1'b0, o_sys_rstn);
        check_bit("early lock", 1'b0, o_lock);
        wait_lock("power-up lock time");
        check_bit("reset released", 1'b1, o_sys_rstn);
        check_bit("loop on", 1'b1, o_pll_enable);
        reg_read(`CTRL_OFS, rd);
        check_word("control reset", ctrl_word(1'b0, 1'b0, 6'h3F, 1'b1, 1'b1), rd);
        check_word("reset fsys", 32'h007FFDA0, o_fsys);
        check_word("reset fvco", 32'h01FFF680, o_fvco);

        // Read-only bits ignore writes; unmapped reads give zero
        reg_write(`CTRL_OFS, 32'h00003F00);
        check_bit("same setting", 1'b1, o_lock);
        reg_read(`CTRL_OFS, rd);
        check_word("control kept", ctrl_word(1'b0, 1'b0, 6'h3F, 1'b1, 1'b1), rd);
        reg_read(8'h20, rd);
        check_word("unmapped", 32'h00000000, rd);

        // Settings across the range, each feedback change relocks
        foreach (cfg[i]) begin
            reg_write(`CTRL_OFS, {16'h0000, cfg[i][7:6], cfg[i][5:0], 8'h00});
            check_bit("lock after change", 1'b0, o_lock);
            repeat (3) @(posedge i_clk);
            #1;
            check_word("fsys", fsys_of(cfg[i][7], cfg[i][6], cfg[i][5:0]), o_fsys);
            check_word("fvco", fsys_of(cfg[i][7], cfg[i][6], cfg[i][5:0])
                       << (cfg[i][6] ? 1 : 2), o_fvco);
            check_bit("divide select", cfg[i][6], o_sys_div_two);
            wait_lock("relock time");
        end

        // Divide select alone: speed changes at once, lock holds
        reg_write(`INT_STS_OFS, 32'h00000003);
        reg_write(`CTRL_OFS, 32'h00004000);
        repeat (3) @(posedge i_clk);
        #1;
        check_bit("lock kept", 1'b1, o_lock);
        check_bit("div two", 1'b1, o_sys_div_two);
        check_word("fsys x", fsys_of(1'b0, 1'b1, 6'h00), o_fsys);
        reg_read(`INT_STS_OFS, rd);
        check_word("no loss event", 32'h00000000, rd);

        // Reference disturbance forces relock; events and interrupt
        @(posedge i_clk);
        i_disturb <= 1'b1;
        @(posedge i_clk);
        i_disturb <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1;
        check_bit("lock on disturb", 1'b0, o_lock);
        wait_lock("relock after disturb");
        reg_read(`INT_STS_OFS, rd);
        check_word("events", 32'h00000003, rd);
        check_bit("masked irq", 1'b0, o_irq);
        reg_write(`INT_MSK_OFS, 32'h00000002);
        check_bit("irq set", 1'b1, o_irq);
        reg_write(`INT_STS_OFS, 32'h00000002);
        check_bit("irq cleared", 1'b0, o_irq);
        reg_read(`INT_STS_OFS, rd);
        check_word("one left", 32'h00000001, rd);
        reg_write(`INT_STS_OFS, 32'h00000001);
        reg_write(`INT_MSK_OFS, 32'h00000001);
        reg_write(`CTRL_OFS, 32'h00004100);
        wait_lock("relock with irq");
        check_bit("lock irq", 1'b1, o_irq);

        // External clock mode: loop off, reset released without lock
        do_reset(1'b0);
        repeat (2) @(posedge i_clk);
        #1;
        check_bit("loop off", 1'b0, o_pll_enable);
        check_bit("ext reset out", 1'b1, o_sys_rstn);
        check_bit("ext lock", 1'b0, o_lock);
        check_word("ext fsys", REF, o_fsys);
        check_word("ext fvco", 32'h00000000, o_fvco);
        reg_read(`CTRL_OFS, rd);
        check_word("ext control", ctrl_word(1'b0, 1'b0, 6'h3F, 1'b0, 1'b0), rd);
        report_and_stop();
    end
endmodule : clock_synthesizer_control_tb
